// ### rtl/tbd_decoder.sv
// Texture block decoder: fetches one 128-bit block and returns one LINEAR_8BIT_OUTPUT texel
`timescale 1ns/1ps
`default_nettype none

module tbd_decoder #(
  parameter int                    COORD_W = 16,
  parameter int                    ADDR_W  = 32,
  parameter logic [63:0][31:0]     PART2   = '0,
  parameter logic [63:0][31:0]     PART3   = '0
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  // Texel request from the sampler
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire logic [COORD_W-1:0]   req_x,
  input  wire logic [COORD_W-1:0]   req_y,
  input  wire logic [COORD_W-1:0]   img_width,
  input  wire logic [ADDR_W-1:0]    img_base,
  input  wire logic                 srgb_alpha_block_format,
  // Block memory
  output logic                      mem_rd_req,
  output logic      [ADDR_W-1:0]    mem_addr,
  input  wire logic                 mem_rd_valid,
  input  wire logic [127:0]         mem_rd_data,
  // Decoded texel
  output logic                      tex_valid,
  output logic      [7:0]           tex_r,
  output logic      [7:0]           tex_g,
  output logic      [7:0]           tex_b,
  output logic      [7:0]           tex_a,
  output logic                      srgb_8bit_output
);

  // ****************************************
  // Location and block decode
  // ****************************************
  logic [ADDR_W-1:0] loc_addr;
  logic [1:0]        loc_x;
  logic [1:0]        loc_y;

  tbd_locate #(
    .COORD_W (COORD_W),
    .ADDR_W  (ADDR_W)
  ) u_locate (
    .x         (req_x),
    .y         (req_y),
    .img_width (img_width),
    .img_base  (img_base),
    .blk_addr  (loc_addr),
    .tex_x     (loc_x),
    .tex_y     (loc_y)
  );

  tbd_pkg::tbd_state_t state_q;
  tbd_pkg::tbd_state_t state_d;
  logic [127:0]        blk_q;
  logic [127:0]        blk_d;
  logic [1:0]          tx_q;
  logic [1:0]          tx_d;
  logic [1:0]          ty_q;
  logic [1:0]          ty_d;
  logic                srgb_q;
  logic                srgb_d;

  logic              mode_ok;
  logic [31:0]       ep0;
  logic [31:0]       ep1;
  logic [3:0]        cidx;
  logic [2:0]        cw;
  logic [3:0]        aidx;
  logic [2:0]        aw;
  logic [1:0]        rot;
  logic [31:0]       blend_rgba;

  // Index field of texel t, with anchors stored one bit short
  function automatic logic [3:0] read_index(input logic [127:0] blk, input int base,
                                            input int w, input int t, input int a1,
                                            input int a2);
    int skip;
    int anc;
    skip = ((t > 0) ? 1 : 0) + ((a1 < t) ? 1 : 0) + ((a2 < t) ? 1 : 0);
    anc  = (t == 0 || t == a1 || t == a2) ? 1 : 0;
    return 4'(tbd_pkg::tbd_get_bits(blk, base + t * w - skip, w - anc));
  endfunction

  // Whole decode is one combinational pass over the held block; trades
  // a long path for a small, simple control section.
  always_comb begin
    int         m, pos, pos_a, pos_p, pos_i, pos_i2;
    int         ns, pb, rb, isb, cb, ab, epb, spb, ib, ib2;
    int         t, s, a1, a2, hp, e, c;
    logic [7:0] part, isel, raw, pv;
    logic       sel2;
    m = 0;
    for (int i = 7; i >= 0; i--) begin
      if (blk_q[i]) begin
        m = i;
      end
    end
    mode_ok = (blk_q[7:0] != tbd_pkg::TBD_RESERVED_LOW);
    ns  = int'(tbd_pkg::TBD_MODE_NS[m]);
    pb  = int'(tbd_pkg::TBD_MODE_PB[m]);
    rb  = int'(tbd_pkg::TBD_MODE_RB[m]);
    isb = int'(tbd_pkg::TBD_MODE_ISB[m]);
    cb  = int'(tbd_pkg::TBD_MODE_CB[m]);
    ab  = int'(tbd_pkg::TBD_MODE_AB[m]);
    epb = int'(tbd_pkg::TBD_MODE_EPB[m]);
    spb = int'(tbd_pkg::TBD_MODE_SPB[m]);
    ib  = int'(tbd_pkg::TBD_MODE_IB[m]);
    ib2 = int'(tbd_pkg::TBD_MODE_IB2[m]);
    // Fields in fixed order after the mode prefix
    pos  = m + 1;
    part = tbd_pkg::tbd_get_bits(blk_q, pos, pb);
    pos  = pos + pb;
    rot  = 2'(tbd_pkg::tbd_get_bits(blk_q, pos, rb));
    pos  = pos + rb;
    isel = tbd_pkg::tbd_get_bits(blk_q, pos, isb);
    pos  = pos + isb;
    // Subset and anchors of this texel
    t  = int'(ty_q) * tbd_pkg::TBD_BLOCK_DIM + int'(tx_q);
    s  = 0;
    a1 = tbd_pkg::TBD_TEXELS;
    a2 = tbd_pkg::TBD_TEXELS;
    if (ns == 2) begin
      s  = int'(PART2[part[5:0]][2*t +: 2]);
      a1 = int'(tbd_pkg::TBD_ANCHOR2[part[5:0]]);
    end else if (ns == 3) begin
      s  = int'(PART3[part[5:0]][2*t +: 2]);
      a1 = int'(tbd_pkg::TBD_ANCHOR3B[part[5:0]]);
      a2 = int'(tbd_pkg::TBD_ANCHOR3C[part[5:0]]);
    end
    pos_a = pos + 6 * ns * cb;
    pos_p = pos_a + 2 * ns * ab;
    pos_i = pos_p + 2 * ns * epb + 2 * spb;
    hp    = (epb + spb > 0) ? 1 : 0;
    ep0   = tbd_pkg::TBD_RGBA_RESET;
    ep1   = tbd_pkg::TBD_RGBA_RESET;
    for (e = 0; e < 2; e++) begin
      if (epb > 0) begin
        pv = tbd_pkg::tbd_get_bits(blk_q, pos_p + s * 2 + e, 1);
      end else begin
        pv = tbd_pkg::tbd_get_bits(blk_q, pos_p + e, spb);
      end
      for (c = 0; c < 4; c++) begin
        if (c < 3) begin
          raw = tbd_pkg::tbd_get_bits(blk_q, pos + cb * (c * 2 * ns + s * 2 + e), cb);
          raw = 8'((raw << hp) | pv);
          raw = tbd_pkg::tbd_expand(raw, cb + hp);
        end else if (ab > 0) begin
          raw = tbd_pkg::tbd_get_bits(blk_q, pos_a + ab * (s * 2 + e), ab);
          raw = 8'((raw << hp) | pv);
          raw = tbd_pkg::tbd_expand(raw, ab + hp);
        end else begin
          raw = tbd_pkg::TBD_FULL_ALPHA;
        end
        if (e == 0) begin
          ep0[8*c +: 8] = raw;
        end else begin
          ep1[8*c +: 8] = raw;
        end
      end
    end
    // Secondary indices follow the primary ones, each set short by ns bits
    pos_i2 = pos_i + tbd_pkg::TBD_TEXELS * ib - ns;
    sel2   = (isb > 0) && isel[0];
    if (sel2) begin
      cidx = read_index(blk_q, pos_i2, ib2, t, a1, a2);
      cw   = 3'(ib2);
    end else begin
      cidx = read_index(blk_q, pos_i, ib, t, a1, a2);
      cw   = 3'(ib);
    end
    if (ib2 > 0 && !sel2) begin
      aidx = read_index(blk_q, pos_i2, ib2, t, a1, a2);
      aw   = 3'(ib2);
    end else begin
      aidx = read_index(blk_q, pos_i, ib, t, a1, a2);
      aw   = 3'(ib);
    end
  end

  tbd_blend u_blend (
    .ep0       (ep0),
    .ep1       (ep1),
    .color_idx (cidx),
    .color_w   (cw),
    .alpha_idx (aidx),
    .alpha_w   (aw),
    .rotation  (rot),
    .rgba      (blend_rgba)
  );

  // ****************************************
  // Control and outputs
  // ****************************************
  logic              ready_d;
  logic              rd_req_d;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic              valid_d;
  logic [31:0]       rgba_q;
  logic [31:0]       rgba_d;
  // Tag follows the texel, not the pending request
  logic              srgb_out_q;
  logic              srgb_out_d;

  always_comb begin
    state_d  = state_q;
    blk_d    = blk_q;
    tx_d     = tx_q;
    ty_d     = ty_q;
    srgb_d   = srgb_q;
    addr_d   = addr_q;
    ready_d  = req_ready;
    rd_req_d = mem_rd_req;
    valid_d  = 1'b0;
    rgba_d   = rgba_q;
    srgb_out_d = srgb_out_q;
    case (state_q)
      tbd_pkg::TBD_IDLE: begin
        if (req_valid && req_ready) begin
          addr_d   = loc_addr;
          tx_d     = loc_x;
          ty_d     = loc_y;
          srgb_d   = srgb_alpha_block_format;
          ready_d  = 1'b0;
          rd_req_d = 1'b1;
          state_d  = tbd_pkg::TBD_FETCH;
        end
      end
      tbd_pkg::TBD_FETCH: begin
        if (mem_rd_valid) begin
          blk_d    = mem_rd_data;
          rd_req_d = 1'b0;
          state_d  = tbd_pkg::TBD_DECODE;
        end
      end
      tbd_pkg::TBD_DECODE: begin
        // Reserved prefix decodes to all-zero texel
        rgba_d  = mode_ok ? blend_rgba : tbd_pkg::TBD_RGBA_RESET;
        srgb_out_d = srgb_q;
        valid_d = 1'b1;
        ready_d = 1'b1;
        state_d = tbd_pkg::TBD_IDLE;
      end
      default: begin
        state_d  = tbd_pkg::TBD_IDLE;
        ready_d  = 1'b1;
        rd_req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q          <= tbd_pkg::TBD_IDLE;
      blk_q            <= '0;
      tx_q             <= 2'h0;
      ty_q             <= 2'h0;
      srgb_q           <= 1'b0;
      addr_q           <= '0;
      req_ready        <= 1'b1;
      mem_rd_req       <= 1'b0;
      tex_valid        <= 1'b0;
      rgba_q           <= tbd_pkg::TBD_RGBA_RESET;
      srgb_out_q       <= 1'b0;
    end else begin
      state_q          <= state_d;
      blk_q            <= blk_d;
      tx_q             <= tx_d;
      ty_q             <= ty_d;
      srgb_q           <= srgb_d;
      addr_q           <= addr_d;
      req_ready        <= ready_d;
      mem_rd_req       <= rd_req_d;
      tex_valid        <= valid_d;
      rgba_q           <= rgba_d;
      srgb_out_q       <= srgb_out_d;
    end
  end

  assign mem_addr         = addr_q;
  assign tex_r            = rgba_q[7:0];
  assign tex_g            = rgba_q[15:8];
  assign tex_b            = rgba_q[23:16];
  assign tex_a            = rgba_q[31:24];
  assign srgb_8bit_output = srgb_out_q;

endmodule

`default_nettype wire

// ### rtl/tbd_pkg.sv
// Constants, tables and helpers shared by the texture block decoder
package tbd_pkg;

  // ****************************************
  // Block geometry and reset values
  // ****************************************
  localparam int          TBD_BLOCK_BITS   = 128;
  localparam int          TBD_BLOCK_BYTES  = 16;
  localparam int          TBD_BLOCK_DIM    = 4;
  localparam int          TBD_TEXELS       = 16;
  localparam int          TBD_WEIGHT_ONE   = 64;
  localparam int          TBD_ROUND        = 32;
  localparam int          TBD_WEIGHT_SHIFT = 6;
  localparam logic [7:0]  TBD_FULL_ALPHA   = 8'hff;
  localparam logic [31:0] TBD_RGBA_RESET   = 32'h0000_0000;
  localparam logic [7:0]  TBD_RESERVED_LOW = 8'h00;

  // ****************************************
  // Per-mode parameters, index is the mode
  // ****************************************
  localparam logic [3:0] TBD_MODE_NS  [8] = '{4'h3, 4'h2, 4'h3, 4'h2, 4'h1, 4'h1, 4'h1, 4'h2};
  localparam logic [3:0] TBD_MODE_PB  [8] = '{4'h4, 4'h6, 4'h6, 4'h6, 4'h0, 4'h0, 4'h0, 4'h6};
  localparam logic [3:0] TBD_MODE_RB  [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h0, 4'h0};
  localparam logic [3:0] TBD_MODE_ISB [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
  localparam logic [3:0] TBD_MODE_CB  [8] = '{4'h4, 4'h6, 4'h5, 4'h7, 4'h5, 4'h7, 4'h7, 4'h5};
  localparam logic [3:0] TBD_MODE_AB  [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h6, 4'h8, 4'h7, 4'h5};
  localparam logic [3:0] TBD_MODE_EPB [8] = '{4'h1, 4'h0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h1, 4'h1};
  localparam logic [3:0] TBD_MODE_SPB [8] = '{4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  localparam logic [3:0] TBD_MODE_IB  [8] = '{4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h2, 4'h4, 4'h2};
  localparam logic [3:0] TBD_MODE_IB2 [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h3, 4'h2, 4'h0, 4'h0};

  // ****************************************
  // Anchor texel tables, index is the partition
  // ****************************************
  localparam logic [3:0] TBD_ANCHOR2 [64] = '{
    4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf,
    4'hf, 4'h2, 4'h8, 4'h2, 4'h2, 4'h8, 4'h8, 4'hf, 4'h2, 4'h8, 4'h2, 4'h2, 4'h8, 4'h8, 4'h2, 4'h2,
    4'hf, 4'hf, 4'h6, 4'h8, 4'h2, 4'h8, 4'hf, 4'hf, 4'h2, 4'h8, 4'h2, 4'h2, 4'h2, 4'hf, 4'hf, 4'h6,
    4'h6, 4'h2, 4'h6, 4'h8, 4'hf, 4'hf, 4'h2, 4'h2, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h2, 4'h2, 4'hf};
  localparam logic [3:0] TBD_ANCHOR3B [64] = '{
    4'h3, 4'h3, 4'hf, 4'hf, 4'h8, 4'h3, 4'hf, 4'hf, 4'h8, 4'h8, 4'h6, 4'h6, 4'h6, 4'h5, 4'h3, 4'h3,
    4'h3, 4'h3, 4'h8, 4'hf, 4'h3, 4'h3, 4'h6, 4'ha, 4'h5, 4'h8, 4'h8, 4'h6, 4'h8, 4'h5, 4'hf, 4'hf,
    4'h8, 4'hf, 4'h3, 4'h5, 4'h6, 4'ha, 4'h8, 4'hf, 4'hf, 4'h3, 4'hf, 4'h5, 4'hf, 4'hf, 4'hf, 4'hf,
    4'h3, 4'hf, 4'h5, 4'h5, 4'h5, 4'h8, 4'h5, 4'ha, 4'h5, 4'ha, 4'h8, 4'hd, 4'hf, 4'hc, 4'h3, 4'h3};
  localparam logic [3:0] TBD_ANCHOR3C [64] = '{
    4'hf, 4'h8, 4'h8, 4'h3, 4'hf, 4'hf, 4'h3, 4'h8, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h8,
    4'hf, 4'h8, 4'hf, 4'h3, 4'hf, 4'h8, 4'hf, 4'h8, 4'h3, 4'hf, 4'h6, 4'ha, 4'hf, 4'hf, 4'ha, 4'h8,
    4'hf, 4'h3, 4'hf, 4'ha, 4'ha, 4'h8, 4'h9, 4'ha, 4'h6, 4'hf, 4'h8, 4'hf, 4'h3, 4'h6, 4'h6, 4'h8,
    4'hf, 4'h3, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h3, 4'hf, 4'hf, 4'h8};

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    TBD_IDLE   = 2'b00,
    TBD_FETCH  = 2'b01,
    TBD_DECODE = 2'b10
  } tbd_state_t;

  // ****************************************
  // Helpers
  // ****************************************
  // Field of w bits (w up to 8) starting at bit pos, upper bits zero
  function automatic logic [7:0] tbd_get_bits(input logic [127:0] blk, input int pos,
                                              input int w);
    logic [127:0] sh;
    logic [8:0]   msk;
    sh  = blk >> pos;
    msk = 9'((10'h1 << w) - 10'h1);
    return sh[7:0] & msk[7:0];
  endfunction

  // Left-justify n bits into a byte, refill the low bits from the top
  function automatic logic [7:0] tbd_expand(input logic [7:0] v, input int n);
    logic [7:0] hi;
    hi = 8'(v << (8 - n));
    return hi | 8'(hi >> n);
  endfunction

endpackage

// ### rtl/tbd_locate.sv
// Block address and in-block position of a texel
`timescale 1ns/1ps
`default_nettype none

module tbd_locate #(
  parameter int COORD_W = 16,
  parameter int ADDR_W  = 32
) (
  // Texel and image
  input  wire logic [COORD_W-1:0] x,
  input  wire logic [COORD_W-1:0] y,
  input  wire logic [COORD_W-1:0] img_width,
  input  wire logic [ADDR_W-1:0]  img_base,
  // Location
  output logic      [ADDR_W-1:0]  blk_addr,
  output logic      [1:0]         tex_x,
  output logic      [1:0]         tex_y
);

  logic [COORD_W:0]     row_blocks;
  logic [2*COORD_W+1:0] blk_index;

  always_comb begin
    row_blocks = (COORD_W+1)'((img_width + (COORD_W+1)'(3)) >> 2);
    blk_index  = (2*COORD_W+2)'(row_blocks * (y >> 2)) + (2*COORD_W+2)'(x >> 2);
    blk_addr   = img_base + ADDR_W'(blk_index * tbd_pkg::TBD_BLOCK_BYTES);
    tex_x      = x[1:0];
    tex_y      = y[1:0];
  end

endmodule

`default_nettype wire

// ### rtl/tbd_blend.sv
// Endpoint interpolation and channel rotation
`timescale 1ns/1ps
`default_nettype none

module tbd_blend (
  // Endpoints, bytes are {a, b, g, r}
  input  wire logic [31:0] ep0,
  input  wire logic [31:0] ep1,
  // Selected indices and their widths
  input  wire logic [3:0]  color_idx,
  input  wire logic [2:0]  color_w,
  input  wire logic [3:0]  alpha_idx,
  input  wire logic [2:0]  alpha_w,
  input  wire logic [1:0]  rotation,
  // Result, {a, b, g, r}
  output logic      [31:0] rgba
);

  // ****************************************
  // Weight lookup
  // ****************************************
  function automatic logic [6:0] weight(input logic [3:0] idx, input logic [2:0] w);
    logic [6:0] r;
    r = 7'h00;
    case (w)
      3'h2: begin
        case (idx[1:0])
          2'h0: r = 7'h00;
          2'h1: r = 7'h15;
          2'h2: r = 7'h2b;
          default: r = 7'h40;
        endcase
      end
      3'h3: begin
        case (idx[2:0])
          3'h0: r = 7'h00;
          3'h1: r = 7'h09;
          3'h2: r = 7'h12;
          3'h3: r = 7'h1b;
          3'h4: r = 7'h25;
          3'h5: r = 7'h2e;
          3'h6: r = 7'h37;
          default: r = 7'h40;
        endcase
      end
      default: begin
        case (idx)
          4'h0: r = 7'h00;  4'h1: r = 7'h04;  4'h2: r = 7'h09;  4'h3: r = 7'h0d;
          4'h4: r = 7'h11;  4'h5: r = 7'h15;  4'h6: r = 7'h1a;  4'h7: r = 7'h1e;
          4'h8: r = 7'h22;  4'h9: r = 7'h26;  4'ha: r = 7'h2b;  4'hb: r = 7'h2f;
          4'hc: r = 7'h33;  4'hd: r = 7'h37;  4'he: r = 7'h3c;
          default: r = 7'h40;
        endcase
      end
    endcase
    return r;
  endfunction

  function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
                                     input logic [6:0] wt);
    logic [15:0] acc;
    acc = 16'((16'(tbd_pkg::TBD_WEIGHT_ONE) - 16'(wt)) * 16'(a)) + 16'(16'(wt) * 16'(b))
        + 16'(tbd_pkg::TBD_ROUND);
    return 8'(acc >> tbd_pkg::TBD_WEIGHT_SHIFT);
  endfunction

  logic [6:0] wc;
  logic [6:0] wa;
  logic [7:0] r;
  logic [7:0] g;
  logic [7:0] b;
  logic [7:0] a;

  always_comb begin
    wc = weight(color_idx, color_w);
    wa = weight(alpha_idx, alpha_w);
    r  = mix(ep0[7:0], ep1[7:0], wc);
    g  = mix(ep0[15:8], ep1[15:8], wc);
    b  = mix(ep0[23:16], ep1[23:16], wc);
    a  = mix(ep0[31:24], ep1[31:24], wa);
    case (rotation)
      2'h1:    rgba = {r, b, g, a};
      2'h2:    rgba = {g, b, a, r};
      2'h3:    rgba = {b, a, g, r};
      default: rgba = {a, b, g, r};
    endcase
  end

endmodule

`default_nettype wire

// ### dv/tbd_monitor.sv
// Port-level checker for the texture block decoder
`timescale 1ns/1ps
`default_nettype none
module tbd_monitor #(
  parameter int ADDR_W = 32
) (
  // Clock, reset and request
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              srgb_alpha_block_format,
  // Block memory
  input wire logic              mem_rd_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic              mem_rd_valid,
  input wire logic [127:0]      mem_rd_data,
  // Texel
  input wire logic              tex_valid,
  input wire logic [7:0]        tex_r,
  input wire logic [7:0]        tex_g,
  input wire logic [7:0]        tex_b,
  input wire logic [7:0]        tex_a,
  input wire logic              srgb_8bit_output
);
  logic fmt_q;
  logic zero_q;
  logic noa_q;
  // ****************************************
  // Facts captured per request
  // ****************************************
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fmt_q  <= 1'b0;
      zero_q <= 1'b0;
      noa_q  <= 1'b0;
    end else begin
      if (req_valid && req_ready) fmt_q <= srgb_alpha_block_format;
      if (mem_rd_req && mem_rd_valid) begin
        zero_q <= (mem_rd_data[7:0] == 8'h00);
        // Modes 0 to 3 carry no alpha bits
        noa_q  <= (mem_rd_data[3:0] != 4'h0);
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ****************************************
  // Assertions
  // ****************************************
  a_take_fetch: assert property (req_valid && req_ready |=> !req_ready && mem_rd_req)
    else $error("fetch did not start after take");
  a_fetch_held: assert property (mem_rd_req && !mem_rd_valid |=> mem_rd_req && $stable(mem_addr))
    else $error("block read dropped or moved");
  a_fetch_done: assert property (mem_rd_req && mem_rd_valid |=> !mem_rd_req ##1 (tex_valid && req_ready))
    else $error("texel not delivered after block");
  a_valid_pulse: assert property (tex_valid |=> !tex_valid)
    else $error("texel valid longer than one cycle");
  a_result_hold: assert property (!tex_valid |-> $stable({tex_a, tex_b, tex_g, tex_r, srgb_8bit_output}))
    else $error("texel changed without valid");
  a_srgb_tag: assert property (tex_valid |-> srgb_8bit_output == fmt_q)
    else $error("output tag differs from format");
  a_reserved_blank: assert property (tex_valid && zero_q |-> {tex_a, tex_b, tex_g, tex_r} == 32'h0)
    else $error("reserved block not blank");
  a_full_alpha: assert property (tex_valid && noa_q && !zero_q |-> tex_a == 8'hff)
    else $error("alpha not full scale");
  c_take: cover property (req_valid && req_ready);
  c_srgb: cover property (tex_valid && srgb_8bit_output);
  c_reserved: cover property (tex_valid && zero_q);
endmodule
bind tbd_decoder tbd_monitor #(.ADDR_W(ADDR_W)) u_mon (.sys_clk, .resetn, .req_valid, .req_ready,
  .srgb_alpha_block_format, .mem_rd_req, .mem_addr, .mem_rd_valid, .mem_rd_data, .tex_valid,
  .tex_r, .tex_g, .tex_b, .tex_a, .srgb_8bit_output);
`default_nettype wire

// ### dv/tbd_mem_model.sv
// Block memory model: one block per read request after a set latency
`timescale 1ns/1ps
`default_nettype none
module tbd_mem_model (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // Request, block contents and latency
  input  wire logic         mem_rd_req,
  input  wire logic [127:0] blk,
  input  wire logic [3:0]   lat,
  // Answer
  output logic              mem_rd_valid,
  output logic      [127:0] mem_rd_data
);
  logic [3:0] cnt_q;
  logic       done_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q        <= 4'h0;
      done_q       <= 1'b0;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 128'h0;
    end else begin
      mem_rd_valid <= 1'b0;
      // Idle data toggles so a stale block never passes for a fresh one
      mem_rd_data  <= ~mem_rd_data;
      if (!mem_rd_req) begin
        cnt_q  <= 4'h0;
        done_q <= 1'b0;
      end else if (!done_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == lat) begin
          mem_rd_valid <= 1'b1;
          mem_rd_data  <= blk;
          done_q       <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/texture_block_decoder_linear_8bit_output_bench.sv
// Self-checking bench for the texture block decoder
`timescale 1ns/1ps
`default_nettype none
module texture_block_decoder_linear_8bit_output_bench;
  // Partition 13: texels 8 to 15 in subset one
  localparam logic [63:0][31:0] P2 = 2048'h5555_0000 << 416;
  logic         sys_clk, resetn, req_valid, req_ready, srgb_alpha_block_format;
  logic         mem_rd_req, mem_rd_valid, tex_valid, srgb_8bit_output;
  logic [15:0]  req_x, req_y, img_width;
  logic [31:0]  img_base, mem_addr;
  logic [127:0] mem_rd_data, blk;
  logic [7:0]   tex_r, tex_g, tex_b, tex_a;
  logic [3:0]   lat;
  int           fail_count, num_checks, pos;
  int           w2[4] = '{0, 21, 43, 64};
  int           w3[8] = '{0, 9, 18, 27, 37, 46, 55, 64};
  int           w4[16] = '{0, 4, 9, 13, 17, 21, 26, 30, 34, 38, 43, 47, 51, 55, 60, 64};

  tbd_decoder #(.PART2(P2)) uut (.sys_clk, .resetn, .req_valid, .req_ready, .req_x, .req_y,
    .img_width, .img_base, .srgb_alpha_block_format, .mem_rd_req, .mem_addr, .mem_rd_valid,
    .mem_rd_data, .tex_valid, .tex_r, .tex_g, .tex_b, .tex_a, .srgb_8bit_output);
  tbd_mem_model u_mem (.sys_clk, .resetn, .mem_rd_req, .blk, .lat, .mem_rd_valid, .mem_rd_data);

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input int v, input int w);
    for (int i = 0; i < w; i++) blk[pos+i] = v[i];
    pos += w;
  endtask
  function automatic int xp(input int v, input int n);
    int hi;
    hi = (v << (8 - n)) & 255;
    return hi | (hi >> n);
  endfunction
  function automatic int mix(input int e0, input int e1, input int w);
    return ((64 - w) * e0 + w * e1 + 32) >> 6;
  endfunction
  task automatic fetch(input int x, input int y, input int wd, input logic f);
    int n;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_x <= 16'(x);
    req_y <= 16'(y);
    img_width <= 16'(wd);
    srgb_alpha_block_format <= f;
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
    check(mem_addr, 32'h1000 + 16 * (((wd + 3) / 4) * (y / 4) + x / 4));
    n = 0;
    while (tex_valid !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check({31'h0, tex_valid}, 32'h1);
    check({31'h0, srgb_8bit_output}, {31'h0, f});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    check({29'h0, req_ready, mem_rd_req, tex_valid}, 32'h4);
    check({tex_a, tex_b, tex_g, tex_r}, 32'h0);
  endtask
  task automatic test_mode6();
    int c[4][2] = '{'{16, 112}, '{0, 127}, '{85, 42}, '{127, 1}};
    int ex;
    blk = '0;
    pos = 0;
    put(64, 7);
    for (int ch = 0; ch < 4; ch++) begin
      for (int e = 0; e < 2; e++) put(c[ch][e], 7);
    end
    put(1, 1);
    put(0, 1);
    put(5, 3);
    for (int t = 1; t < 16; t++) put(t, 4);
    lat = 4'h0;
    for (int t = 0; t < 16; t++) begin
      fetch(8 + t % 4, 4 + t / 4, 13, 1'b0);
      ex = 0;
      for (int ch = 0; ch < 4; ch++) begin
        ex |= mix(c[ch][0] * 2 + 1, c[ch][1] * 2, w4[t == 0 ? 5 : t]) << (8 * ch);
      end
      check({tex_a, tex_b, tex_g, tex_r}, 32'(ex));
    end
  endtask
  task automatic test_mode4();
    int c[4][2] = '{'{3, 28}, '{17, 9}, '{31, 0}, '{5, 60}};
    int v[4];
    int cw, aw, tmp;
    for (int m = 0; m < 8; m++) begin
      blk = '0;
      pos = 0;
      put(16, 5);
      put(m / 2, 2);
      put(m % 2, 1);
      for (int ch = 0; ch < 4; ch++) begin
        for (int e = 0; e < 2; e++) put(c[ch][e], ch < 3 ? 5 : 6);
      end
      put(0, 1);
      for (int t = 1; t < 16; t++) put(t % 4, 2);
      put(0, 2);
      for (int t = 1; t < 16; t++) put(t % 8, 3);
      lat = 4'h3;
      fetch(6, 1, 8, 1'b0);
      cw = (m % 2) ? w3[6] : w2[2];
      aw = (m % 2) ? w2[2] : w3[6];
      for (int ch = 0; ch < 4; ch++) begin
        v[ch] = mix(xp(c[ch][0], ch < 3 ? 5 : 6), xp(c[ch][1], ch < 3 ? 5 : 6), ch < 3 ? cw : aw);
      end
      if (m / 2 != 0) begin
        tmp = v[3];
        v[3] = v[m/2-1];
        v[m/2-1] = tmp;
      end
      check({tex_a, tex_b, tex_g, tex_r}, {8'(v[3]), 8'(v[2]), 8'(v[1]), 8'(v[0])});
    end
  endtask
  task automatic test_mode1();
    int c[3][2][2] = '{'{'{1, 62}, '{40, 20}}, '{'{63, 0}, '{7, 50}}, '{'{33, 33}, '{12, 45}}};
    int ex, s;
    blk = '0;
    pos = 0;
    put(2, 2);
    put(13, 6);
    for (int ch = 0; ch < 3; ch++) begin
      for (int k = 0; k < 4; k++) put(c[ch][k/2][k%2], 6);
    end
    put(1, 1);
    put(0, 1);
    for (int t = 0; t < 16; t++) put((t == 0 || t == 15) ? t % 4 : t % 8, (t % 15 == 0) ? 2 : 3);
    lat = 4'h1;
    for (int t = 0; t < 16; t++) begin
      fetch(t % 4, t / 4, 4, 1'b1);
      s = t / 8;
      ex = 32'hff00_0000;
      for (int ch = 0; ch < 3; ch++) begin
        ex |= mix(xp(c[ch][s][0] * 2 + 1, 7), xp(c[ch][s][1] * 2, 7), w3[t == 15 ? 3 : t % 8]) << (8 * ch);
      end
      check({tex_a, tex_b, tex_g, tex_r}, 32'(ex));
    end
  endtask
  task automatic test_reserved();
    blk = {{120{1'b1}}, 8'h00};
    lat = 4'h5;
    fetch(0, 0, 4, 1'b0);
    check({tex_a, tex_b, tex_g, tex_r}, 32'h0);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    #50000;
    fail_count++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    req_valid = 1'b0;
    req_x = 16'h0;
    req_y = 16'h0;
    img_width = 16'h0;
    img_base = 32'h1000;
    srgb_alpha_block_format = 1'b0;
    blk = '0;
    lat = 4'h0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    test_reset();
    test_mode6();
    test_mode4();
    test_mode1();
    test_reserved();
    complete_run();
  end
endmodule
`default_nettype wire
